// file: design/sbw_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbw_defines.svh"
module sbw_regs (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       spi_chip_select_n,
    input  wire logic       spi_sclk,
    input  wire logic       spi_mosi,
    output logic            spi_miso,
    output logic            spi_miso_oe,
    input  wire sbw_pkg::sbw_evt_s evt,
    input  wire logic       system_error_flag,
    input  wire logic       failure_flag,
    input  wire logic       failure_detected,
    input  wire logic       dev_wdog_wr,
    input  wire logic [2:0] dev_wdog_period,
    input  wire logic       dev_wdog_stop_off,
    input  wire logic       dev_can_wr,
    input  wire logic [1:0] dev_can_low,
    input  wire logic       dev_lin_wr,
    input  wire logic [1:0] dev_lin_mode,
    input  wire logic [1:0] restart_lin_mode,
    input  wire logic [1:0] restart_can_low,
    output logic            failure_outputs,
    output sbw_pkg::sbw_mode_e mode_request,
    output logic            soft_reset_req,
    output logic            aux_reg_voltage_cfg,
    output logic            aux_reg_load_sharing,
    output logic            wdog_parity_ok,
    output logic            stop_wdog_off_low,
    output logic            wdog_type_select,
    output logic            wdog_start_on_bus_wake,
    output logic [2:0]      wdog_period_field,
    output logic            lin_flash_mode,
    output logic            lin_low_slope_select,
    output logic            lin_tx_timeout_enable,
    output sbw_pkg::sbw_trx_e lin_mode,
    output sbw_pkg::sbw_trx_e can_mode,
    output logic            selective_wake,
    output logic [7:0]      external_wake_control
);
    import sbw_pkg::*;

    sbw_spi_if  spi ();
    logic [7:0] mode_q;
    logic [7:0] hw_q;
    logic [7:0] wdog_q;
    logic [7:0] bus_q;
    logic [7:0] ext_q;
    logic       fo_hw_q;
    logic       parity_q;
    logic       slope_flash_q;
    logic       slope_lsm_q;
    logic       wr_mode;
    logic       wr_hw;
    logic       wr_wdog;
    logic       wr_bus;
    logic       wr_ext;
    logic [7:0] rdata;

    // Bus control reset image, indexed for the slope flops
    localparam logic [7:0] BUS_RST = `SBW_BUS_CTRL_RST;

    // Even parity over a byte
    function automatic logic even_parity(input logic [7:0] v);
        even_parity = ~(^v);
    endfunction : even_parity

    // Write strobe for one address
    function automatic logic wr_hit(input logic [6:0] a, input logic [6:0] t,
                                    input logic v, input logic w);
        wr_hit = v & w & (a == t);
    endfunction : wr_hit

    ////////////////////////////////////////////////////////////////////
    // SPI shifter
    sbw_spi_shift u_shift (
        .core_clk          (core_clk),
        .reset             (reset),
        .spi_chip_select_n (spi_chip_select_n),
        .spi_sclk          (spi_sclk),
        .spi_mosi          (spi_mosi),
        .spi_miso          (spi_miso),
        .spi_miso_oe       (spi_miso_oe),
        .bus               (spi.shifter)
    );

    // Address decode of completed write frames
    assign wr_mode = wr_hit(spi.addr, `SBW_ADDR_MODE_SUPPLY,
                            spi.frame_valid, spi.write);
    assign wr_hw   = wr_hit(spi.addr, `SBW_ADDR_HW_CTRL,
                            spi.frame_valid, spi.write);
    assign wr_wdog = wr_hit(spi.addr, `SBW_ADDR_WDOG_CTRL,
                            spi.frame_valid, spi.write);
    assign wr_bus  = wr_hit(spi.addr, `SBW_ADDR_BUS_CTRL,
                            spi.frame_valid, spi.write);
    assign wr_ext  = wr_hit(spi.addr, `SBW_ADDR_EXT_WAKE,
                            spi.frame_valid, spi.write);

    ////////////////////////////////////////////////////////////////////
    // Mode byte: the whole written byte is kept here
    always_ff @(posedge core_clk) begin
        if (reset || evt.por || evt.soft_reset) begin
            mode_q <= 8'h00;
        end else if (evt.enter_restart) begin
            mode_q <= {2'h0, mode_q[5:0]};
        end else if (wr_mode) begin
            mode_q <= spi.wdata;
        end
    end

    assign mode_request   = sbw_mode_e'(mode_q[7:6]);
    assign soft_reset_req = (mode_q[7:6] == SBW_MODE_SOFT);

    ////////////////////////////////////////////////////////////////////
    // Hardware control register
    always_ff @(posedge core_clk) begin
        if (reset || evt.por) begin
            hw_q <= `SBW_HW_CTRL_RST;
        end else if (evt.soft_reset) begin
            hw_q <= hw_q & `SBW_HW_KEEP_MASK;
        end else if (evt.enter_restart) begin
            hw_q[`SBW_HW_FOSW_BIT] <= 1'b0;
        end else if (wr_hw) begin
            hw_q <= spi.wdata;
            hw_q[`SBW_HW_RSVD_BIT] <= 1'b0;
        end
    end

    // Failure-driven output latch; failure wins over its release
    always_ff @(posedge core_clk) begin
        if (reset || evt.por) begin
            fo_hw_q <= 1'b0;
        end else if (failure_detected) begin
            fo_hw_q <= 1'b1;
        end else if (!failure_flag) begin
            fo_hw_q <= 1'b0;
        end
    end

    assign failure_outputs      = fo_hw_q | hw_q[`SBW_HW_FOSW_BIT];
    assign aux_reg_voltage_cfg  = hw_q[`SBW_HW_VCFG_BIT];
    assign aux_reg_load_sharing = hw_q[`SBW_HW_LS_BIT];

    ////////////////////////////////////////////////////////////////////
    // Watchdog control register
    always_ff @(posedge core_clk) begin
        if (reset || evt.por || evt.soft_reset) begin
            wdog_q   <= `SBW_WDOG_CTRL_RST;
            parity_q <= 1'b1;
        end else if (wr_wdog) begin
            wdog_q   <= spi.wdata & `SBW_WD_WMASK;
            parity_q <= even_parity(spi.wdata);
        end else if (dev_wdog_wr) begin
            wdog_q[`SBW_WD_STOP_BIT] <= dev_wdog_stop_off;
            wdog_q[2:0]              <= dev_wdog_period;
        end
    end

    assign wdog_parity_ok         = parity_q;
    assign stop_wdog_off_low      = wdog_q[`SBW_WD_STOP_BIT];
    assign wdog_type_select       = wdog_q[`SBW_WD_TYPE_BIT];
    assign wdog_start_on_bus_wake = wdog_q[`SBW_WD_BUSWK_BIT];
    assign wdog_period_field      = wdog_q[2:0];

    ////////////////////////////////////////////////////////////////////
    // Bus control register; events ordered by priority
    always_ff @(posedge core_clk) begin
        if (reset || evt.por || evt.soft_reset) begin
            bus_q <= `SBW_BUS_CTRL_RST;
        end else if (evt.enter_failsafe) begin
            bus_q[4:0] <= `SBW_BUS_FS_LOW;
        end else if (evt.enter_restart) begin
            bus_q[4:3] <= restart_lin_mode;
            bus_q[1:0] <= restart_can_low;
        end else if (evt.enter_sleep) begin
            if (!system_error_flag && bus_q[1])
                bus_q[1:0] <= SBW_TRX_WAKE;
        end else if (evt.enter_stop) begin
            bus_q <= bus_q;
        end else if (wr_bus) begin
            bus_q <= spi.wdata;
        end else begin
            if (dev_lin_wr)
                bus_q[4:3] <= dev_lin_mode;
            if (dev_can_wr)
                bus_q[1:0] <= dev_can_low;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || evt.por || evt.soft_reset) begin
            slope_flash_q <= BUS_RST[`SBW_BUS_FLASH_BIT];
            slope_lsm_q   <= BUS_RST[`SBW_BUS_LSM_BIT];
        end else if (spi.cs_rise) begin
            slope_flash_q <= wr_bus ? spi.wdata[`SBW_BUS_FLASH_BIT]
                                    : bus_q[`SBW_BUS_FLASH_BIT];
            slope_lsm_q   <= wr_bus ? spi.wdata[`SBW_BUS_LSM_BIT]
                                    : bus_q[`SBW_BUS_LSM_BIT];
        end
    end

    assign lin_flash_mode        = slope_flash_q;
    assign lin_low_slope_select  = slope_lsm_q;
    assign lin_tx_timeout_enable = bus_q[`SBW_BUS_TXTO_BIT];

    sbw_mode_decode u_decode (
        .bus_ctrl           (bus_q),
        .lin_mode           (lin_mode),
        .can_mode           (can_mode),
        .can_selective_wake (selective_wake)
    );

    ////////////////////////////////////////////////////////////////////
    // External wake control register
    always_ff @(posedge core_clk) begin
        if (reset || evt.por || evt.soft_reset) begin
            ext_q <= `SBW_EXT_WAKE_RST;
        end else if (evt.enter_failsafe) begin
            ext_q <= (ext_q & ~`SBW_EXT_FS_CLR_MASK) | `SBW_EXT_FS_SET;
        end else if (wr_ext) begin
            ext_q <= spi.wdata & ~8'h58;
        end
    end

    assign external_wake_control = ext_q;

    ////////////////////////////////////////////////////////////////////
    // Read-back mux, captured at frame start
    always_comb begin
        unique case (spi.addr)
            `SBW_ADDR_MODE_SUPPLY: rdata = mode_q;
            `SBW_ADDR_HW_CTRL:     rdata = hw_q;
            `SBW_ADDR_WDOG_CTRL:   rdata = wdog_q;
            `SBW_ADDR_BUS_CTRL:    rdata = bus_q;
            `SBW_ADDR_EXT_WAKE:    rdata = ext_q;
            default:               rdata = 8'h00;
        endcase
    end
    assign spi.rdata = rdata;
endmodule : sbw_regs
`default_nettype wire

// file: shared/sbw_defines.svh
`ifndef SBW_DEFINES_SVH
`define SBW_DEFINES_SVH
// Register addresses (7-bit)
`define SBW_ADDR_MODE_SUPPLY 7'h01
`define SBW_ADDR_HW_CTRL     7'h02
`define SBW_ADDR_WDOG_CTRL   7'h03
`define SBW_ADDR_BUS_CTRL    7'h04
`define SBW_ADDR_EXT_WAKE    7'h07
// Reset values
`define SBW_HW_CTRL_RST      8'h00
`define SBW_WDOG_CTRL_RST    8'h00
`define SBW_BUS_CTRL_RST     8'h20
`define SBW_EXT_WAKE_RST     8'h07
// Hardware control fields
`define SBW_HW_VCFG_BIT      7
`define SBW_HW_FOSW_BIT      5
`define SBW_HW_LS_BIT        3
`define SBW_HW_RSVD_BIT      2
`define SBW_HW_KEEP_MASK     8'h88
// Watchdog control fields
`define SBW_WD_STOP_BIT      6
`define SBW_WD_TYPE_BIT      5
`define SBW_WD_BUSWK_BIT     4
`define SBW_WD_RSVD_BIT      3
`define SBW_WD_WMASK         8'hf7
// Bus control fields
`define SBW_BUS_FLASH_BIT    7
`define SBW_BUS_LSM_BIT      6
`define SBW_BUS_TXTO_BIT     5
`define SBW_BUS_SWK_BIT      2
`define SBW_BUS_FS_LOW       5'h09
`define SBW_BUS_FS_MASK      8'h1f
// External wake fail-safe pattern: bits 6,4,3 zero, 2:0 ones
`define SBW_EXT_FS_CLR_MASK  8'h58
`define SBW_EXT_FS_SET       8'h07
// SPI frame
`define SBW_FRAME_BITS       16
`endif

// file: shared/sbw_pkg.sv
package sbw_pkg;
    // Device mode field codes
    typedef enum logic [1:0] {
        SBW_MODE_NORMAL = 2'h0,
        SBW_MODE_SLEEP  = 2'h1,
        SBW_MODE_STOP   = 2'h2,
        SBW_MODE_SOFT   = 2'h3
    } sbw_mode_e;
    // Transceiver mode decode
    typedef enum logic [1:0] {
        SBW_TRX_OFF     = 2'h0,
        SBW_TRX_WAKE    = 2'h1,
        SBW_TRX_RXONLY  = 2'h2,
        SBW_TRX_NORMAL  = 2'h3
    } sbw_trx_e;
    // Device events that rewrite registers
    typedef struct packed {
        logic enter_sleep;
        logic enter_stop;
        logic enter_restart;
        logic enter_failsafe;
        logic soft_reset;
        logic por;
    } sbw_evt_s;
endpackage : sbw_pkg

// file: shared/sbw_spi_if.sv
`timescale 1ns/1ps
`default_nettype none
// Frame handoff from the SPI shifter to the register bank
interface sbw_spi_if;
    logic       frame_valid;
    logic [6:0] addr;
    logic       write;
    logic [7:0] wdata;
    logic       cs_rise;
    logic       cs_fall;
    logic [7:0] rdata;
    modport shifter (output frame_valid, output addr, output write,
                     output wdata, output cs_rise, output cs_fall,
                     input rdata);
    modport bank    (input frame_valid, input addr, input write,
                     input wdata, input cs_rise, input cs_fall,
                     output rdata);
endinterface : sbw_spi_if
`default_nettype wire

// file: design/sbw_spi_shift.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbw_defines.svh"
// 16-bit SPI slave, mode 0, sampled on core_clk
module sbw_spi_shift (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic spi_chip_select_n,
    input  wire logic spi_sclk,
    input  wire logic spi_mosi,
    output logic      spi_miso,
    output logic      spi_miso_oe,
    sbw_spi_if.shifter bus
);
    logic [1:0] csn_sync_q;
    logic [1:0] sclk_sync_q;
    logic [1:0] mosi_sync_q;
    logic       csn_prev_q;
    logic       sclk_prev_q;
    logic [15:0] shift_q;
    logic [15:0] out_q;
    logic [4:0]  count_q;
    logic        sclk_rise;
    logic        sclk_fall;

    ////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            csn_sync_q  <= 2'h3;
            sclk_sync_q <= 2'h0;
            mosi_sync_q <= 2'h0;
            csn_prev_q  <= 1'b1;
            sclk_prev_q <= 1'b0;
        end else begin
            csn_sync_q  <= {csn_sync_q[0], spi_chip_select_n};
            sclk_sync_q <= {sclk_sync_q[0], spi_sclk};
            mosi_sync_q <= {mosi_sync_q[0], spi_mosi};
            csn_prev_q  <= csn_sync_q[1];
            sclk_prev_q <= sclk_sync_q[1];
        end
    end

    assign sclk_rise   = sclk_sync_q[1] & ~sclk_prev_q & ~csn_sync_q[1];
    assign sclk_fall   = ~sclk_sync_q[1] & sclk_prev_q & ~csn_sync_q[1];
    assign bus.cs_fall = ~csn_sync_q[1] & csn_prev_q;
    assign bus.cs_rise = csn_sync_q[1] & ~csn_prev_q;

    ////////////////////////////////////////////////////////////////////
    // Shift in on rising edges, out on falling edges
    always_ff @(posedge core_clk) begin
        if (reset) begin
            shift_q <= 16'h0000;
            out_q   <= 16'h0000;
            count_q <= 5'h00;
        end else if (bus.cs_fall) begin
            count_q <= 5'h00;
            out_q   <= {8'h00, bus.rdata};
        end else if (sclk_rise) begin
            shift_q <= {shift_q[14:0], mosi_sync_q[1]};
            if (count_q != 5'h1f)
                count_q <= count_q + 5'h01;
        end else if (sclk_fall) begin
            out_q <= {out_q[14:0], 1'b0};
        end
    end

    // Frame complete only with exactly 16 bits on chip-select rise
    assign bus.frame_valid = bus.cs_rise &&
                             (count_q == 5'(`SBW_FRAME_BITS));
    assign bus.write       = shift_q[15];
    assign bus.addr        = shift_q[14:8];
    assign bus.wdata       = shift_q[7:0];
    assign spi_miso        = out_q[15];
    assign spi_miso_oe     = ~csn_sync_q[1];
endmodule : sbw_spi_shift
`default_nettype wire

// file: design/sbw_mode_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Decodes the bus-control register into transceiver controls
module sbw_mode_decode (
    input  wire logic [7:0]         bus_ctrl,
    output sbw_pkg::sbw_trx_e       lin_mode,
    output sbw_pkg::sbw_trx_e       can_mode,
    output logic                    can_selective_wake
);
    import sbw_pkg::*;
    // LIN field bits 4:3, CAN field low bits 1:0, bit 2 selective wake
    assign lin_mode           = sbw_trx_e'(bus_ctrl[4:3]);
    // CAN low bits and selective wake
    assign can_mode           = sbw_trx_e'(bus_ctrl[1:0]);
    assign can_selective_wake = bus_ctrl[2];
endmodule : sbw_mode_decode
`default_nettype wire

// file: dv/sbw_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sbw_regs_checker (
    input wire logic               core_clk,
    input wire logic               reset,
    input wire logic               spi_chip_select_n,
    input wire sbw_pkg::sbw_evt_s  evt,
    input wire logic               system_error_flag,
    input wire logic               failure_flag,
    input wire logic               failure_detected,
    input wire logic [1:0]         restart_lin_mode,
    input wire logic [1:0]         restart_can_low,
    input wire logic               failure_outputs,
    input wire sbw_pkg::sbw_mode_e mode_request,
    input wire logic               soft_reset_req,
    input wire logic               lin_flash_mode,
    input wire logic               lin_low_slope_select,
    input wire logic               lin_tx_timeout_enable,
    input wire sbw_pkg::sbw_trx_e  lin_mode,
    input wire sbw_pkg::sbw_trx_e  can_mode,
    input wire logic               selective_wake,
    input wire logic [7:0]         external_wake_control
);
    import sbw_pkg::*;
    logic [3:0] idle_q;
    logic       one_evt;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // Cycles since select went high
    always_ff @(posedge core_clk) begin
        if (reset || !spi_chip_select_n) begin
            idle_q <= 4'h0;
        end else if (idle_q != 4'hf) begin
            idle_q <= idle_q + 4'h1;
        end
    end
    // A lone event this cycle
    assign one_evt = $onehot(evt);
    ////////////////////////////////////////////////////////////////
    sequence s_fail_held;
        failure_detected ##1 failure_flag [*4];
    endsequence
    sequence s_restart;
        evt.enter_restart && one_evt;
    endsequence
    soft_req_a: assert property (
        soft_reset_req == (mode_request == SBW_MODE_SOFT))
        else $error("soft reset request mismatch");
    fo_hold_a: assert property (
        s_fail_held |-> failure_outputs)
        else $error("failure outputs dropped");
    restart_fo_a: assert property (
        evt.enter_restart && !failure_flag && !failure_detected
        |=> !failure_outputs) else $error("outputs kept on restart");
    reset_bus_a: assert property (
        (evt.por || evt.soft_reset) |=> lin_tx_timeout_enable &&
        lin_mode == SBW_TRX_OFF && can_mode == SBW_TRX_OFF &&
        !selective_wake && external_wake_control == 8'h07)
        else $error("bad reset value");
    failsafe_a: assert property (
        evt.enter_failsafe && one_evt |=> lin_mode == SBW_TRX_WAKE &&
        can_mode == SBW_TRX_WAKE && !selective_wake &&
        $stable(lin_tx_timeout_enable) &&
        (external_wake_control & 8'h5f) == 8'h07)
        else $error("bad fail-safe value");
    sleep_can_a: assert property (
        evt.enter_sleep && one_evt && !system_error_flag && can_mode[1]
        |=> can_mode == SBW_TRX_WAKE && $stable(selective_wake))
        else $error("sleep did not set wake");
    stop_keep_a: assert property (
        evt.enter_stop && one_evt
        |=> $stable(can_mode) && $stable(selective_wake))
        else $error("stop changed can mode");
    restart_bus_a: assert property (
        s_restart |=> lin_mode == $past(restart_lin_mode) &&
        can_mode == $past(restart_can_low) && $stable(selective_wake) &&
        $stable(lin_tx_timeout_enable))
        else $error("bad restart value");
    slope_cs_a: assert property (
        ($changed(lin_low_slope_select) || $changed(lin_flash_mode)) &&
        $past(evt) == '0 && $past(evt, 2) == '0 && !$past(reset)
        |-> idle_q inside {[1:6]}) else $error("slope change off select");
endmodule : sbw_regs_checker
bind sbw_regs sbw_regs_checker i_chk (.*);
`default_nettype wire

// file: dv/sbw_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the 16-bit serial link, mode 0
module sbw_host (
    output logic     spi_chip_select_n,
    output logic     spi_sclk,
    output logic     spi_mosi,
    input wire logic spi_miso
);
    // Idle: select high, clock parked low
    initial begin
        spi_chip_select_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
    end
    // One frame of nb bits, MSB first, read on rising clock
    task automatic xfer(input logic [15:0] w, input int nb,
                        output logic [15:0] r);
        r = 16'h0000;
        spi_chip_select_n = 1'b0;
        for (int i = 15; i > 15 - nb; i--) begin
            spi_mosi = w[i];
            #80 spi_sclk = 1'b1;
            r = {r[14:0], spi_miso};
            #80 spi_sclk = 1'b0;
        end
        spi_mosi = ~spi_mosi; // Inverted data, no stale level
        #80 spi_chip_select_n = 1'b1;
        #200;
    endtask : xfer
endmodule : sbw_host
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sbw_pkg::*;
    typedef struct packed {
        logic [6:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } sbw_row_s;
    // Register writes and the value they leave
    localparam sbw_row_s rows [13] = '{
        '{7'h04, 8'h00, 8'h00}, '{7'h04, 8'h89, 8'h89},
        '{7'h04, 8'h52, 8'h52}, '{7'h04, 8'h3b, 8'h3b},
        '{7'h04, 8'h04, 8'h04}, '{7'h04, 8'hcd, 8'hcd},
        '{7'h04, 8'h16, 8'h16}, '{7'h04, 8'hff, 8'hff},
        '{7'h03, 8'h00, 8'h00}, '{7'h03, 8'hff, 8'hf7},
        '{7'h03, 8'h01, 8'h01}, '{7'h03, 8'h96, 8'h96},
        '{7'h03, 8'h7c, 8'h74}};
    // Start value, event, error flag, result
    localparam logic [22:0] sl_tab [6] = '{
        {8'h0b, 6'h20, 1'b0, 8'h09}, {8'h06, 6'h20, 1'b0, 8'h05},
        {8'h03, 6'h20, 1'b1, 8'h03}, {8'h02, 6'h10, 1'b0, 8'h02},
        {8'h00, 6'h10, 1'b0, 8'h00}, {8'h05, 6'h20, 1'b0, 8'h05}};
    logic       core_clk, reset, spi_chip_select_n, spi_sclk, spi_mosi;
    logic       spi_miso, spi_miso_oe, system_error_flag, failure_flag;
    logic       failure_detected, dev_wdog_wr, dev_wdog_stop_off;
    logic       dev_can_wr, dev_lin_wr, failure_outputs, soft_reset_req;
    logic       aux_reg_voltage_cfg, aux_reg_load_sharing, wdog_parity_ok;
    logic       stop_wdog_off_low, wdog_type_select, wdog_start_on_bus_wake;
    logic       lin_flash_mode, lin_low_slope_select, lin_tx_timeout_enable;
    logic       selective_wake;
    logic [2:0] dev_wdog_period, wdog_period_field;
    logic [1:0] dev_can_low, dev_lin_mode, restart_lin_mode, restart_can_low;
    logic [7:0] external_wake_control;
    sbw_evt_s   evt;
    sbw_mode_e  mode_request;
    sbw_trx_e   lin_mode, can_mode;
    int         errors, num_checks;
    sbw_regs i_dut (.*);
    sbw_host i_host (.*);
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [15:0] r;
        i_host.xfer({1'b1, a, d}, 16, r);
    endtask : wr
    // Second frame returns the register named by the first
    task automatic rchk(input logic [6:0] a, input logic [7:0] e);
        logic [15:0] r;
        i_host.xfer({1'b0, a, 8'h00}, 16, r);
        i_host.xfer({1'b0, a, 8'h00}, 16, r);
        chk(r[7:0], e);
    endtask : rchk
    task automatic pulse(input sbw_evt_s e);
        @(negedge core_clk) evt = e;
        @(negedge core_clk) evt = '0;
        repeat (2) @(negedge core_clk);
    endtask : pulse
    // Decoded outputs laid out like the register
    function automatic logic [7:0] obs(input logic [6:0] a,
                                       input logic [7:0] e);
        if (a == 7'h04) begin
            return {lin_flash_mode, lin_low_slope_select,
                    lin_tx_timeout_enable, lin_mode, selective_wake,
                    can_mode};
        end
        return {e[7], stop_wdog_off_low, wdog_type_select,
                wdog_start_on_bus_wake, e[3], wdog_period_field};
    endfunction : obs
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Run needs about 250 us
    initial begin
        #1_000_000;
        errors++;
        end_sim();
    end
    initial begin
        reset = 1'b1;
        evt = '0;
        {system_error_flag, failure_flag, failure_detected} = 3'h0;
        {dev_wdog_wr, dev_wdog_stop_off, dev_can_wr, dev_lin_wr} = 4'h0;
        {dev_wdog_period, dev_can_low, dev_lin_mode} = 7'h00;
        {restart_lin_mode, restart_can_low} = 4'h0;
        errors = 0;
        num_checks = 0;
        repeat (20) @(negedge core_clk);
        reset = 1'b0;
        repeat (3) @(negedge core_clk);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk(obs(rows[i].a, rows[i].e), rows[i].e);
            rchk(rows[i].a, rows[i].e);
            if (rows[i].a == 7'h03) begin
                chk({7'h0, wdog_parity_ok}, {7'h0, ~^rows[i].d});
            end
        end
        $display("test table done");
        @(negedge core_clk) reset = 1'b1;
        @(negedge core_clk) reset = 1'b0;
        repeat (3) @(negedge core_clk);
        chk({7'h0, spi_miso_oe}, 8'h00);
        rchk(7'h04, 8'h20);
        rchk(7'h03, 8'h00);
        @(negedge core_clk) begin
            {dev_wdog_wr, dev_wdog_stop_off, dev_wdog_period} = 5'h1d;
        end
        @(negedge core_clk) dev_wdog_wr = 1'b0;
        rchk(7'h03, 8'h45);
        $display("test reset done");
        foreach (sl_tab[i]) begin
            wr(7'h04, sl_tab[i][22:15]);
            system_error_flag = sl_tab[i][8];
            pulse(sl_tab[i][14:9]);
            rchk(7'h04, sl_tab[i][7:0]);
        end
        system_error_flag = 1'b0;
        @(negedge core_clk) begin
            {dev_can_wr, dev_can_low, dev_lin_wr, dev_lin_mode} = 6'h37;
        end
        @(negedge core_clk) {dev_can_wr, dev_lin_wr} = 2'h0;
        rchk(7'h04, 8'h1e);
        $display("test sleep stop done");
        wr(7'h04, 8'hff);
        wr(7'h07, 8'hff);
        pulse(6'h04);
        rchk(7'h04, 8'he9);
        rchk(7'h07, 8'ha7);
        $display("test fail-safe done");
        wr(7'h01, 8'hc0);
        chk({7'h0, soft_reset_req}, 8'h01);
        wr(7'h01, 8'h40);
        chk({6'h0, mode_request}, 8'h01);
        wr(7'h02, 8'h20);
        wr(7'h04, 8'hff);
        chk({7'h0, failure_outputs}, 8'h01);
        {restart_lin_mode, restart_can_low} = 4'hb;
        pulse(6'h08);
        chk({7'h0, failure_outputs}, 8'h00);
        rchk(7'h02, 8'h00);
        rchk(7'h04, 8'hf7);
        chk({6'h0, mode_request}, 8'h00);
        $display("test restart done");
        failure_flag = 1'b1;
        @(negedge core_clk) failure_detected = 1'b1;
        @(negedge core_clk) failure_detected = 1'b0;
        wr(7'h02, 8'h20);
        wr(7'h02, 8'h00);
        chk({7'h0, failure_outputs}, 8'h01);
        failure_flag = 1'b0;
        repeat (3) @(negedge core_clk);
        chk({7'h0, failure_outputs}, 8'h00);
        $display("test failure done");
        wr(7'h02, 8'hff);
        rchk(7'h02, 8'hfb);
        pulse(6'h02);
        rchk(7'h02, 8'h88);
        chk({6'h0, aux_reg_voltage_cfg, aux_reg_load_sharing}, 8'h03);
        pulse(6'h01);
        rchk(7'h02, 8'h00);
        $display("test soft reset done");
        end_sim();
    end
endmodule : tb
`default_nettype wire
